// [src/arcr_regs.sv]
`timescale 1ns/10ps
module arcr_regs
  import arcr_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr, // register address of the access
  input wire logic [7:0] reg_wdata, // write data
  input wire logic reg_wr, // write strobe, one cycle
  input wire logic reg_rd, // read strobe, one cycle
  input wire logic [2:0] wake_power_setting, // power-mode field used by wake rates
  input wire logic [2:0] sniff_power_setting, // power-mode field used by sniff rates
  input wire logic [2:0] operating_mode_code, // current mode control code
  output logic [7:0] reg_rdata, // read data, one cycle after the strobe
  output logic reg_rd_hit, // read addressed one of these registers
  output logic [3:0] wake_rate_code,
  output logic [3:0] activity_detect_rate_code,
  output logic [2:0] idle_clock_rate_code,
  output logic [15:0] wake_rate_dhz, // wake rate, tenths of hertz
  output logic wake_rate_valid,
  output logic [15:0] sniff_rate_dhz, // sniff rate, tenths of hertz
  output logic sniff_rate_valid,
  output logic continuous_sampling_mode,
  output logic sniff_mode_active,
  output logic standby_mode_active,
  output logic wake_rate15_armed,
  output logic sniff_rate15_armed,
  output logic [7:0] rate15_value1,
  output logic [7:0] rate15_value2
);
  logic [7:0] wake_reg_q; // stored wake rate register
  logic [7:0] sniff_reg_q; // stored sniff control register
  logic [7:0] rdata_q;
  logic rd_hit_q;
  arcr_seq_e seq_q;
  logic seq_sniff_q; // sequence is the sniff variant
  logic wake_arm_q;
  logic sniff_arm_q;
  logic [7:0] val1_q;
  logic [7:0] val2_q;
  logic wr_wake; // write to wake register
  logic wr_sniff; // write to sniff register
  logic wr_trig; // write to trigger count register

  assign wr_wake = reg_wr && (reg_addr == ARCR_WAKE_RATE_ADDR);
  assign wr_sniff = reg_wr && (reg_addr == ARCR_SNIFF_RATE_ADDR);
  assign wr_trig = reg_wr && (reg_addr == ARCR_TRIG_COUNT_ADDR);

  // register storage, whole byte kept so reads return what was written
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wake_reg_q <= ARCR_WAKE_RATE_RST;
      sniff_reg_q <= ARCR_SNIFF_RATE_RST;
    end else begin
      if (wr_wake) begin
        wake_reg_q <= reg_wdata; // upper nibble unused by the decode; setup sequence bytes from the host set it
      end
      if (wr_sniff) begin
        sniff_reg_q <= reg_wdata; // bit four kept zero by the host
      end
    end
  end

  // read port, data one cycle after the strobe, zero when not ours
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
      rd_hit_q <= 1'b0;
    end else begin
      rd_hit_q <= reg_rd && (reg_addr == ARCR_WAKE_RATE_ADDR || reg_addr == ARCR_SNIFF_RATE_ADDR);
      if (reg_rd && reg_addr == ARCR_WAKE_RATE_ADDR) begin
        rdata_q <= wake_reg_q;
      end else if (reg_rd && reg_addr == ARCR_SNIFF_RATE_ADDR) begin
        rdata_q <= sniff_reg_q;
      end else begin
        rdata_q <= 8'h00;
      end
    end
  end

  // follows the top-rate setup sequence by snooping writes
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      seq_q <= ARCR_S_IDLE;
      seq_sniff_q <= 1'b0;
    end else if (wr_wake && reg_wdata == ARCR_SEQ_POINT) begin
      seq_q <= ARCR_S_PTR0; // point step restarts the sequence
    end else if (wr_wake || wr_trig) begin
      unique case (seq_q)
        ARCR_S_PTR0: begin
          if (wr_trig && reg_wdata == ARCR_SEQ_SET1_WAKE) begin
            seq_q <= ARCR_S_SET1;
            seq_sniff_q <= 1'b0;
          end else if (wr_trig && reg_wdata == ARCR_SEQ_SET1_SNIFF) begin
            seq_q <= ARCR_S_SET1;
            seq_sniff_q <= 1'b1;
          end else begin
            seq_q <= ARCR_S_IDLE;
          end
        end
        ARCR_S_SET1: begin
          seq_q <= (wr_wake && reg_wdata == (seq_sniff_q ? ARCR_SEQ_SET2_SNIFF : ARCR_SEQ_SET2_WAKE))
                   ? ARCR_S_SET2 : ARCR_S_IDLE;
        end
        ARCR_S_SET2: begin
          seq_q <= (wr_trig && reg_wdata == ARCR_SEQ_SET3) ? ARCR_S_SET3 : ARCR_S_IDLE;
        end
        ARCR_S_SET3: begin
          seq_q <= (wr_wake && reg_wdata == (seq_sniff_q ? ARCR_SEQ_PTR1_SNIFF : ARCR_SEQ_PTR1_WAKE))
                   ? ARCR_S_PTR1 : ARCR_S_IDLE;
        end
        ARCR_S_PTR1: begin
          seq_q <= wr_trig ? ARCR_S_VAL1 : ARCR_S_IDLE;
        end
        ARCR_S_VAL1: begin
          seq_q <= (wr_wake && reg_wdata == (seq_sniff_q ? ARCR_SEQ_PTR2_SNIFF : ARCR_SEQ_PTR2_WAKE))
                   ? ARCR_S_PTR2 : ARCR_S_IDLE;
        end
        ARCR_S_PTR2: begin
          seq_q <= wr_trig ? ARCR_S_VAL2 : ARCR_S_IDLE;
        end
        ARCR_S_VAL2: begin
          seq_q <= ARCR_S_IDLE; // apply write or abort both end it
        end
        ARCR_S_IDLE: begin
          seq_q <= ARCR_S_IDLE;
        end
        default: seq_q <= ARCR_S_IDLE;
      endcase
    end
  end

  // captured setup values
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      val1_q <= 8'h00;
      val2_q <= 8'h00;
    end else begin
      if (wr_trig && seq_q == ARCR_S_PTR1) begin
        val1_q <= reg_wdata; // value picked by power mode
      end
      if (wr_trig && seq_q == ARCR_S_PTR2) begin
        val2_q <= reg_wdata;
      end
    end
  end

  // armed once the apply write ends a complete sequence
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      wake_arm_q <= 1'b0;
      sniff_arm_q <= 1'b0;
    end else if (wr_wake && seq_q == ARCR_S_VAL2 && reg_wdata == ARCR_SEQ_APPLY) begin
      wake_arm_q <= wake_arm_q | !seq_sniff_q;
      sniff_arm_q <= sniff_arm_q | seq_sniff_q;
    end else if (wr_wake && reg_wdata == ARCR_SEQ_POINT) begin
      wake_arm_q <= 1'b0; // a new setup of either kind drops both old ones
      sniff_arm_q <= 1'b0;
    end
  end

  // field split of the two registers
  assign wake_rate_code = wake_reg_q[ARCR_WAKE_CODE_LSB +: 4];
  assign activity_detect_rate_code = sniff_reg_q[ARCR_SNIFF_CODE_LSB +: 4];
  assign idle_clock_rate_code = sniff_reg_q[ARCR_IDLE_CLK_LSB +: 3];

  // wake rate decode
  arcr_rate_lut #(.IS_SNIFF(1'b0)) u_wake_lut (
    .power_setting(wake_power_setting),
    .rate_code(wake_rate_code),
    .rate15_armed(wake_arm_q),
    .rate_dhz(wake_rate_dhz),
    .rate_valid(wake_rate_valid)
  );

  // sniff rate decode
  arcr_rate_lut #(.IS_SNIFF(1'b1)) u_sniff_lut (
    .power_setting(sniff_power_setting),
    .rate_code(activity_detect_rate_code),
    .rate15_armed(sniff_arm_q),
    .rate_dhz(sniff_rate_dhz),
    .rate_valid(sniff_rate_valid)
  );

  // mode decode
  assign continuous_sampling_mode = (operating_mode_code == ARCR_OP_CONTINUOUS_SAMPLING_MODE);
  assign sniff_mode_active = (operating_mode_code == ARCR_OP_SNIFF);
  assign standby_mode_active = (operating_mode_code == ARCR_OP_STANDBY);
  assign reg_rdata = rdata_q;
  assign reg_rd_hit = rd_hit_q;
  assign wake_rate15_armed = wake_arm_q;
  assign sniff_rate15_armed = sniff_arm_q;
  assign rate15_value1 = val1_q;
  assign rate15_value2 = val2_q;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_wr_wake; wr_wake && reg_wdata != ARCR_SEQ_POINT; endsequence
  property p_wake_readback;
    s_wr_wake ##1 !wr_wake ##1 (reg_rd && reg_addr == ARCR_WAKE_RATE_ADDR) |=> reg_rdata == $past(reg_wdata, 3);
  endproperty
  a_wake_readback: assert property (p_wake_readback) else $error("wake read mismatch");
  property p_sniff_hold;
    !wr_sniff |=> sniff_reg_q == $past(sniff_reg_q);
  endproperty
  a_sniff_hold: assert property (p_sniff_hold) else $error("sniff register changed");
  property p_ulp_100;
    wake_power_setting == ARCR_PWR_ULP && wake_rate_code == 4'h8 |-> wake_rate_dhz == 16'd1000 && wake_rate_valid;
  endproperty
  a_ulp_100: assert property (p_ulp_100) else $error("ulp wake rate wrong");
  property p_lp_0c;
    wake_power_setting == ARCR_PWR_LP && wake_rate_code == 4'hC |-> !wake_rate_valid;
  endproperty
  a_lp_0c: assert property (p_lp_0c) else $error("lp 0x0C not flagged");
  property p_prec_09;
    wake_power_setting == ARCR_PWR_PREC && wake_rate_code == 4'h9 |-> !wake_rate_valid;
  endproperty
  a_prec_09: assert property (p_prec_09) else $error("prec 0x09 not flagged");
  property p_sniff_prec;
    sniff_power_setting == ARCR_PWR_PREC && activity_detect_rate_code == 4'h1 |-> sniff_rate_dhz == 16'd2;
  endproperty
  a_sniff_prec: assert property (p_sniff_prec) else $error("sniff prec rate wrong");
  property p_idle_field;
    wr_sniff |=> idle_clock_rate_code == $past(reg_wdata[7:5]) && activity_detect_rate_code == $past(reg_wdata[3:0]);
  endproperty
  a_idle_field: assert property (p_idle_field) else $error("sniff fields wrong");
  property p_continuous_sampling_mode;
    operating_mode_code == ARCR_OP_CONTINUOUS_SAMPLING_MODE |-> continuous_sampling_mode && !sniff_mode_active;
  endproperty
  a_continuous_sampling_mode: assert property (p_continuous_sampling_mode) else $error("mode decode wrong");
  property p_arm;
    wr_wake && seq_q == ARCR_S_VAL2 && reg_wdata == ARCR_SEQ_APPLY && !seq_sniff_q |=> wake_rate15_armed;
  endproperty
  a_arm: assert property (p_arm) else $error("rate 15 not armed");
  property p_unarmed15;
    wake_rate_code == ARCR_RATE15 && !wake_arm_q |-> !wake_rate_valid;
  endproperty
  a_unarmed15: assert property (p_unarmed15) else $error("rate 15 valid unarmed");
endmodule // arcr_regs

// [src/arcr_pkg.sv]
package arcr_pkg;
  // register addresses on the control port
  localparam logic [7:0] ARCR_WAKE_RATE_ADDR = 8'h11;
  localparam logic [7:0] ARCR_SNIFF_RATE_ADDR = 8'h12;
  localparam logic [7:0] ARCR_TRIG_COUNT_ADDR = 8'h29;
  // reset values
  localparam logic [7:0] ARCR_WAKE_RATE_RST = 8'h00;
  localparam logic [7:0] ARCR_SNIFF_RATE_RST = 8'h00;
  // field positions
  localparam int ARCR_WAKE_CODE_LSB = 0;
  localparam int ARCR_SNIFF_CODE_LSB = 0;
  localparam int ARCR_IDLE_CLK_LSB = 5;
  // power mode settings
  localparam logic [2:0] ARCR_PWR_ULP = 3'h3;
  localparam logic [2:0] ARCR_PWR_LP = 3'h0;
  localparam logic [2:0] ARCR_PWR_PREC = 3'h4;
  // operating mode codes
  localparam logic [2:0] ARCR_OP_STANDBY = 3'h1;
  localparam logic [2:0] ARCR_OP_SNIFF = 3'h2;
  localparam logic [2:0] ARCR_OP_CONTINUOUS_SAMPLING_MODE = 3'h5;
  // top rate code that needs the setup sequence
  localparam logic [3:0] ARCR_RATE15 = 4'hF;
  // setup sequence values
  localparam logic [7:0] ARCR_SEQ_POINT = 8'h10;
  localparam logic [7:0] ARCR_SEQ_SET1_WAKE = 8'h03;
  localparam logic [7:0] ARCR_SEQ_SET1_SNIFF = 8'h30;
  localparam logic [7:0] ARCR_SEQ_SET2_WAKE = 8'h20;
  localparam logic [7:0] ARCR_SEQ_SET2_SNIFF = 8'h30;
  localparam logic [7:0] ARCR_SEQ_SET3 = 8'h01;
  localparam logic [7:0] ARCR_SEQ_PTR1_WAKE = 8'h40;
  localparam logic [7:0] ARCR_SEQ_PTR1_SNIFF = 8'h60;
  localparam logic [7:0] ARCR_SEQ_PTR2_WAKE = 8'h50;
  localparam logic [7:0] ARCR_SEQ_PTR2_SNIFF = 8'h70;
  localparam logic [7:0] ARCR_SEQ_APPLY = 8'h0F;
  // setup sequence progress
  typedef enum logic [3:0] {
    ARCR_S_IDLE, ARCR_S_PTR0, ARCR_S_SET1, ARCR_S_SET2, ARCR_S_SET3,
    ARCR_S_PTR1, ARCR_S_VAL1, ARCR_S_PTR2, ARCR_S_VAL2
  } arcr_seq_e;
endpackage

// [src/arcr_rate_lut.sv]
`timescale 1ns/10ps
// turns a rate code and power setting into a rate in tenths of a hertz
module arcr_rate_lut
  import arcr_pkg::*;
#(
  parameter bit IS_SNIFF = 1'b0
) (
  input wire logic [2:0] power_setting,
  input wire logic [3:0] rate_code,
  input wire logic rate15_armed,
  output logic [15:0] rate_dhz,
  output logic rate_valid
);
  // wake table, tenths of Hz, zero where not available
  function automatic logic [15:0] wake_dhz(input logic [2:0] pm, input logic [3:0] c);
    logic [15:0] r;
    r = 16'h0000;
    if (pm == ARCR_PWR_ULP) begin
      unique case (c)
        4'h6: r = 16'd250;
        4'h7: r = 16'd500;
        4'h8: r = 16'd1000;
        4'h9: r = 16'd1900;
        4'hA: r = 16'd3800;
        4'hB: r = 16'd7500;
        4'hC: r = 16'd11000;
        4'hF: r = 16'd13000;
        default: r = 16'h0000; // 0x05 and others unavailable
      endcase
    end else if (pm == ARCR_PWR_LP) begin
      unique case (c)
        4'h5: r = 16'd140;
        4'h6: r = 16'd280;
        4'h7: r = 16'd540;
        4'h8: r = 16'd1050;
        4'h9: r = 16'd2100;
        4'hA: r = 16'd4000;
        4'hB: r = 16'd6000;
        4'hF: r = 16'd7500;
        default: r = 16'h0000; // 0x0C unavailable
      endcase
    end else if (pm == ARCR_PWR_PREC) begin
      unique case (c)
        4'h5: r = 16'd140;
        4'h6: r = 16'd280;
        4'h7: r = 16'd550;
        4'h8: r = 16'd800;
        4'hF: r = 16'd1000;
        default: r = 16'h0000; // 0x09 to 0x0C unavailable
      endcase
    end
    return r;
  endfunction

  // sniff table, tenths of Hz
  function automatic logic [15:0] sniff_dhz(input logic [2:0] pm, input logic [3:0] c);
    logic [15:0] r;
    r = 16'h0000;
    if (pm == ARCR_PWR_ULP) begin
      unique case (c)
        4'h0, 4'h4: r = 16'd60;
        4'h1: r = 16'd4;
        4'h2: r = 16'd8;
        4'h3: r = 16'd15;
        4'h5: r = 16'd130;
        4'h6: r = 16'd250;
        4'h7: r = 16'd500;
        4'h8: r = 16'd1000;
        4'h9: r = 16'd1900;
        4'hA: r = 16'd3800;
        4'hB: r = 16'd7500;
        4'hF: r = 16'd13000;
        default: r = 16'h0000;
      endcase
    end else if (pm == ARCR_PWR_LP) begin
      unique case (c)
        4'h0, 4'h4: r = 16'd70;
        4'h1: r = 16'd4;
        4'h2: r = 16'd8;
        4'h3: r = 16'd15;
        4'h5: r = 16'd140;
        4'h6: r = 16'd280;
        4'h7: r = 16'd540;
        4'h8: r = 16'd1050;
        4'h9: r = 16'd2100;
        4'hA: r = 16'd4000;
        4'hB: r = 16'd6000;
        4'hF: r = 16'd7500;
        default: r = 16'h0000;
      endcase
    end else if (pm == ARCR_PWR_PREC) begin
      unique case (c)
        4'h0, 4'h4: r = 16'd70;
        4'h1: r = 16'd2;
        4'h2: r = 16'd4;
        4'h3: r = 16'd9;
        4'h5: r = 16'd140;
        4'h6: r = 16'd280;
        4'h7: r = 16'd550;
        4'h8: r = 16'd800;
        4'hF: r = 16'd1000;
        default: r = 16'h0000; // 1001 to 1110 unavailable
      endcase
    end
    return r;
  endfunction

  // pick the table; the top code only counts once its setup ran
  always_comb begin
    rate_dhz = IS_SNIFF ? sniff_dhz(power_setting, rate_code) : wake_dhz(power_setting, rate_code);
    rate_valid = (rate_dhz != 16'h0000) && ((rate_code != ARCR_RATE15) || rate15_armed);
  end
endmodule // arcr_rate_lut

// [verif/arcr_host_model.sv]
`timescale 1ns/10ps
// host on the far side of the control port: byte writes and reads
module arcr_host_model
  import arcr_pkg::*;
(
  input wire logic ref_clk,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd
);
  // bus starts idle
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // one write; address and data scrambled after, so stale bytes never look valid
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~d;
  endtask
  // one read strobe
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    reg_addr <= ~a;
  endtask
  // top rate setup; brk selects a step before which a stray rate write breaks it
  task automatic rate15(input bit snf, input logic [2:0] pm, input logic [7:0] v1, input logic [7:0] v2,
                        input int brk);
    logic [7:0] v[9];
    v = '{ARCR_SEQ_POINT, snf ? 8'h30 : 8'h03, snf ? 8'h30 : 8'h20, 8'h01, snf ? 8'h60 : 8'h40, v1,
          snf ? 8'h70 : 8'h50, v2, 8'h0F};
    wr(8'h10, 8'h01);
    wr(8'h15, 8'h04);
    wr(8'h16, 8'h5D);
    wr(8'h1C, snf ? {1'b0, pm, 4'h0} : {5'h00, pm});
    for (int i = 0; i < 9; i++) begin
      // stray write only when a scenario asks for a broken sequence
      if (i == brk) begin
        wr(ARCR_WAKE_RATE_ADDR, 8'h08);
      end
      wr(i % 2 ? ARCR_TRIG_COUNT_ADDR : ARCR_WAKE_RATE_ADDR, v[i]);
    end
    wr(8'h10, snf ? 8'h02 : 8'h05);
  endtask
endmodule // arcr_host_model

// [verif/tb.sv]
`timescale 1ns/10ps
// self-checking bench for the rate register pair
module tb;
  import arcr_pkg::*;
  // expected rates in tenths of hertz; 0 unavailable, -1 not checked
  localparam int WK[3][16] = '{'{-1,-1,-1,-1,-1,0,250,500,1000,1900,3800,7500,11000,-1,-1,0},
    '{-1,-1,-1,-1,-1,140,280,540,1050,2100,4000,6000,0,-1,-1,0}, '{-1,-1,-1,-1,-1,140,280,550,800,0,0,0,0,-1,-1,0}};
  localparam int SN[3][16] = '{'{60,4,8,15,60,130,250,500,1000,1900,3800,7500,-1,-1,-1,0},
    '{70,4,8,15,70,140,280,540,1050,2100,4000,6000,-1,-1,-1,0}, '{70,2,4,9,70,140,280,550,800,0,0,0,-1,-1,-1,0}};
  localparam logic [2:0] PM[3] = '{ARCR_PWR_ULP, ARCR_PWR_LP, ARCR_PWR_PREC};
  localparam int R15[3] = '{13000, 7500, 1000};
  localparam logic [7:0] V1[3] = '{8'h52, 8'h72, 8'h32};
  localparam logic [7:0] V2[3] = '{8'h01, 8'h02, 8'h12};
  logic ref_clk, rst_n, reg_wr, reg_rd, reg_rd_hit, wake_rate_valid, sniff_rate_valid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, rate15_value1, rate15_value2, d;
  logic [2:0] wps, sps, opm, idle_clock_rate_code;
  logic [3:0] wake_rate_code, activity_detect_rate_code;
  logic [15:0] wake_rate_dhz, sniff_rate_dhz;
  logic continuous_sampling_mode, sniff_mode_active, standby_mode_active, wake_rate15_armed, sniff_rate15_armed;
  logic [31:0] r;
  logic [8:0] exp_q[$]; // read notes: hit and data
  logic [8:0] note;
  logic rd_seen = 1'b0;
  int seed, n_errors = 0, samples_checked = 0, cycles = 0;
  // clock
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  arcr_host_model host_u (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd));
  arcr_regs dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .wake_power_setting(wps), .sniff_power_setting(sps), .operating_mode_code(opm),
    .reg_rdata(reg_rdata), .reg_rd_hit(reg_rd_hit), .wake_rate_code(wake_rate_code),
    .activity_detect_rate_code(activity_detect_rate_code), .idle_clock_rate_code(idle_clock_rate_code),
    .wake_rate_dhz(wake_rate_dhz), .wake_rate_valid(wake_rate_valid), .sniff_rate_dhz(sniff_rate_dhz),
    .sniff_rate_valid(sniff_rate_valid), .continuous_sampling_mode(continuous_sampling_mode),
    .sniff_mode_active(sniff_mode_active), .standby_mode_active(standby_mode_active),
    .wake_rate15_armed(wake_rate15_armed), .sniff_rate15_armed(sniff_rate15_armed),
    .rate15_value1(rate15_value1), .rate15_value2(rate15_value2));
  // value compare
  task automatic chk_val(input string n, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // flag compare
  task automatic chk_bit(input string n, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %b seen %b", n, e, g);
    end
  endtask
  // rate and valid pair; negative expectation is skipped
  task automatic chk_rate(input string n, input int e, input logic [15:0] g, input logic v);
    if (e >= 0) begin
      chk_val(n, e[15:0], g);
      chk_bit(n, e > 0, v);
    end
  endtask
  // verdict
  task automatic conclude();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // read monitor: the cycle after a taken strobe holds the answer
  always @(posedge ref_clk) begin
    if (rd_seen) begin
      note = exp_q.size() ? exp_q.pop_front() : 9'h1FF;
      chk_val("read", {7'h00, note}, {7'h00, reg_rd_hit, reg_rdata});
    end
    rd_seen <= reg_rd;
  end
  // hang guard
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      conclude();
    end
  end
  // main sequence
  initial begin
    seed = 32'h7579;
    rst_n = 1'b0;
    wps = ARCR_PWR_ULP;
    sps = ARCR_PWR_ULP;
    opm = 3'h0;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    exp_q.push_back(9'h100);
    host_u.rd(ARCR_WAKE_RATE_ADDR);
    exp_q.push_back(9'h100);
    host_u.rd(ARCR_SNIFF_RATE_ADDR);
    exp_q.push_back(9'h000);
    host_u.rd(ARCR_TRIG_COUNT_ADDR);
    // every code in every power setting
    for (int m = 0; m < 3; m++) begin
      @(posedge ref_clk);
      wps <= PM[m];
      sps <= PM[m];
      for (int c = 0; c < 16; c++) begin
        r = $random(seed);
        d = {r[7:5], 1'b0, c[3:0]};
        host_u.wr(ARCR_WAKE_RATE_ADDR, {4'h0, c[3:0]});
        // wake read right behind its write, so the readback assertion gets exercised
        exp_q.push_back({5'h10, c[3:0]});
        host_u.rd(ARCR_WAKE_RATE_ADDR);
        host_u.wr(ARCR_SNIFF_RATE_ADDR, d);
        @(negedge ref_clk);
        chk_val("wake code", c[15:0], {12'h000, wake_rate_code});
        chk_val("sniff code", c[15:0], {12'h000, activity_detect_rate_code});
        chk_val("idle clock", {13'h0000, d[7:5]}, {13'h0000, idle_clock_rate_code});
        if (c == 15) begin
          // top code keeps its rate but is valid only once its own setup is armed;
          // wake is never armed here, sniff stays armed from the previous round
          chk_val("wake rate15 code", R15[m][15:0], wake_rate_dhz);
          chk_bit("wake valid15 code", 1'b0, wake_rate_valid);
          chk_val("sniff rate15 code", R15[m][15:0], sniff_rate_dhz);
          chk_bit("sniff valid15 code", m > 0, sniff_rate_valid);
        end else begin
          chk_rate("wake rate", WK[m][c], wake_rate_dhz, wake_rate_valid);
          chk_rate("sniff rate", SN[m][c], sniff_rate_dhz, sniff_rate_valid);
        end
        exp_q.push_back({1'b1, d});
        host_u.rd(ARCR_SNIFF_RATE_ADDR);
      end
      // wake top rate after the full setup
      host_u.rate15(1'b0, PM[m], V1[m], V2[m], -1);
      @(negedge ref_clk);
      chk_bit("wake armed", 1'b1, wake_rate15_armed);
      chk_val("value1", {8'h00, V1[m]}, {8'h00, rate15_value1});
      chk_val("value2", {8'h00, V2[m]}, {8'h00, rate15_value2});
      chk_rate("wake rate15", R15[m], wake_rate_dhz, wake_rate_valid);
      // sniff top rate after its own setup
      host_u.rate15(1'b1, PM[m], V1[m], V2[m], -1);
      host_u.wr(ARCR_SNIFF_RATE_ADDR, 8'h0F);
      @(negedge ref_clk);
      chk_bit("sniff armed", 1'b1, sniff_rate15_armed);
      chk_rate("sniff rate15", R15[m], sniff_rate_dhz, sniff_rate_valid);
    end
    // sequence broken mid-way leaves the top rate unusable
    host_u.rate15(1'b0, PM[2], V1[2], V2[2], 4);
    @(negedge ref_clk);
    chk_bit("wake armed", 1'b0, wake_rate15_armed);
    chk_val("wake rate15 unarmed", R15[2][15:0], wake_rate_dhz);
    chk_bit("wake valid15 unarmed", 1'b0, wake_rate_valid);
    // mode decode
    for (int i = 0; i < 8; i++) begin
      @(posedge ref_clk);
      opm <= i[2:0];
      @(negedge ref_clk);
      chk_bit("wake mode", i == 5, continuous_sampling_mode);
      chk_bit("sniff mode", i == 2, sniff_mode_active);
      chk_bit("standby mode", i == 1, standby_mode_active);
    end
    // arm the sniff top rate again so the reset has something to clear
    host_u.rate15(1'b1, PM[0], V1[0], V2[0], -1);
    @(negedge ref_clk);
    chk_bit("sniff rearmed", 1'b1, sniff_rate15_armed);
    // second reset in mid-run clears everything
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    exp_q.push_back(9'h100);
    host_u.rd(ARCR_WAKE_RATE_ADDR);
    exp_q.push_back(9'h100);
    host_u.rd(ARCR_SNIFF_RATE_ADDR);
    @(negedge ref_clk);
    chk_bit("armed after reset", 1'b0, sniff_rate15_armed);
    chk_val("value1 after reset", 16'h0000, {8'h00, rate15_value1});
    repeat (4) @(posedge ref_clk);
    chk_val("pending reads", 16'h0000, 16'(exp_q.size()));
    conclude();
  end
endmodule // tb
